/* File: verilog/eeprom_config_word_loader.sv */
`timescale 1ns/1ps
`default_nettype none
module eeprom_config_word_loader (
  // clock, reset, enable
  input  wire  logic                              i_ref_clk,
  input  wire  logic                              i_arst_n,
  input  wire  logic                              i_ce,
  // preload words from the eeprom reader
  input  wire  logic                              i_ee_valid,
  input  wire  logic [7:0]                        i_ee_addr,
  input  wire  logic [cfg_loader_pkg::EE_W-1:0]   i_ee_data,
  input  wire  logic                              i_ee_last,
  // avalon-mm slave
  input  wire  logic [cfg_loader_pkg::AV_ADDR_W-1:0] i_avs_address,
  input  wire  logic                              i_avs_read,
  input  wire  logic                              i_avs_write,
  input  wire  logic [31:0]                       i_avs_writedata,
  input  wire  logic [3:0]                        i_avs_byteenable,
  output logic [31:0]                             o_avs_readdata,
  output logic                                    o_avs_waitrequest,
  // loader state and configuration image
  output logic                                    o_load_done,
  output cfg_loader_pkg::image_t                  o_cfg_image,
  // per-port control levels taken from the image
  output logic [cfg_loader_pkg::NUM_PORTS-1:0]    o_gen2_mode,
  output logic [cfg_loader_pkg::NUM_PORTS-1:0]    o_msi_disable,
  output logic [cfg_loader_pkg::NUM_PORTS-1:0]    o_pm_disable,
  output logic [cfg_loader_pkg::NUM_PORTS-1:0]    o_short_sof_latency,
  output logic [cfg_loader_pkg::NUM_PORTS-1:0]    o_inta_request
);
  import cfg_loader_pkg::*;

  // all state of the loader
  typedef struct packed {
    fsm_t      fsm;
    logic      done;
    logic      ack;
    reg_word_t rdata;
    logic [7:0] words;
    image_t    img;
  } loader_state_t;

  loader_state_t st;
  loader_state_t next_st;

  cfg_link_if lnk ();

  // byte-lane merge for software writes
  function automatic reg_word_t be_merge(input reg_word_t old_w,
                                         input reg_word_t new_w,
                                         input logic [3:0] be);
    reg_word_t res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  // address decode and word unpack
  cfg_addr_decode u_decode (
    .lnk (lnk)
  );

  cfg_word_unpack u_unpack (
    .lnk (lnk)
  );

  // feed the helpers
  assign lnk.bus_addr = i_avs_address;
  assign lnk.ee_addr  = i_ee_addr;
  assign lnk.ee_data  = i_ee_data;

  // next-state logic
  always_comb begin
    reg_word_t rd;
    reg_word_t msk;
    logic      req;
    logic      reload;
    reg_word_t ctl;
    rd      = '0;
    msk     = '0;
    ctl     = '0;
    req     = i_avs_read || i_avs_write;
    reload  = 1'b0;
    next_st = st;

    // preload words only land while loading
    if (st.fsm == LOADING && i_ee_valid && lnk.upd_hit) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        for (int r = 0; r < NUM_REGS; r++) begin
          msk = lnk.upd_mask_all[r];
          if (HI_PORTS[p]) begin
            msk = msk | lnk.upd_mask_hi[r];
          end
          // only mapped bits change, the rest keep their value
          next_st.img[p][r] = (st.img[p][r] & ~msk) |
                              (lnk.upd_value[r] & msk);
        end
      end
      next_st.words = 8'(st.words + 8'h1);
    end

    // read data mux
    if (lnk.dec_img) begin
      rd = st.img[lnk.dec_port][lnk.dec_idx];
    end else if (lnk.dec_stat) begin
      rd[STAT_DONE_BIT]            = st.done;
      rd[STAT_LOADING_BIT]         = (st.fsm == LOADING);
      rd[STAT_COUNT_POS +: 8]      = st.words;
    end

    // bus slave: hold off host until the load is over
    if (st.fsm == READY) begin
      if (st.ack) begin
        next_st.ack = 1'b0;
        if (i_avs_write) begin
          if (lnk.dec_img) begin
            next_st.img[lnk.dec_port][lnk.dec_idx] =
              be_merge(st.img[lnk.dec_port][lnk.dec_idx],
                       i_avs_writedata, i_avs_byteenable);
          end else if (lnk.dec_ctrl) begin
            ctl    = be_merge(RST_IMAGE, i_avs_writedata, i_avs_byteenable);
            reload = ctl[CTRL_RELOAD_BIT];
          end
        end
      end else if (req) begin
        next_st.ack   = 1'b1;
        next_st.rdata = i_avs_read ? rd : st.rdata;
      end
    end

    // software reload reopens the load window
    if (reload) begin
      next_st.fsm   = LOADING;
      next_st.done  = 1'b0;
      next_st.words = RST_COUNT;
      next_st.ack   = 1'b0;
    end

    // end of preload; set wins over a same-cycle reload
    if (i_ee_last) begin
      next_st.fsm  = READY;
      next_st.done = 1'b1;
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st.fsm   <= LOADING;
      st.done  <= 1'b0;
      st.ack   <= 1'b0;
      st.rdata <= RST_IMAGE;
      st.words <= RST_COUNT;
      st.img   <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  // bus outputs
  assign o_avs_readdata    = st.rdata;
  assign o_avs_waitrequest = !(st.fsm == READY && st.ack);
  assign o_load_done       = st.done;
  assign o_cfg_image       = st.img;

  // per-port control levels
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign o_gen2_mode[p]   = st.img[p][IDX_TL_CTRL][POS_GEN2];
    assign o_msi_disable[p] = st.img[p][IDX_CAP_DIS][POS_MSI_DIS];
    assign o_pm_disable[p]  = st.img[p][IDX_CAP_DIS][POS_PM_DIS];
    // zero selects the short latency mode
    assign o_short_sof_latency[p] =
      !st.img[p][IDX_TL_CTRL][POS_SOF_LAT];
    assign o_inta_request[p] = st.img[p][IDX_INT_PIN][POS_INTA];
  end

endmodule : eeprom_config_word_loader
`default_nettype wire

/* File: verilog/cfg_loader_pkg.sv */
`default_nettype none
package cfg_loader_pkg;

  // sizes
  localparam int NUM_PORTS = 3;
  localparam int NUM_REGS  = 9;
  localparam int WORD_W    = 32;
  localparam int EE_W      = 16;
  localparam int AV_ADDR_W = 10;
  localparam int FIELD3_W  = 15;

  // preload word addresses handled here
  localparam logic [7:0] EE_WORD_ATTR   = 8'h0c;
  localparam logic [7:0] EE_WORD_MARGIN = 8'h0e;
  localparam logic [7:0] EE_WORD_NOMDRV = 8'h10;
  localparam logic [7:0] EE_WORD_DEEMPH = 8'h12;

  // configuration offsets of the per-port image registers
  localparam logic [7:0] OFS_INT_PIN  = 8'h3c;
  localparam logic [7:0] OFS_CAP_DIS  = 8'h70;
  localparam logic [7:0] OFS_PHY0     = 8'h74;
  localparam logic [7:0] OFS_PHY1     = 8'h78;
  localparam logic [7:0] OFS_TL_CTRL  = 8'h8c;
  localparam logic [7:0] OFS_MARGIN   = 8'h94;
  localparam logic [7:0] OFS_DEV_CAP  = 8'hc4;
  localparam logic [7:0] OFS_LINK_CAP = 8'hcc;
  localparam logic [7:0] OFS_DEV_CAP2 = 8'he4;

  // image index of each register
  localparam logic [3:0] IDX_INT_PIN  = 4'h0;
  localparam logic [3:0] IDX_CAP_DIS  = 4'h1;
  localparam logic [3:0] IDX_PHY0     = 4'h2;
  localparam logic [3:0] IDX_PHY1     = 4'h3;
  localparam logic [3:0] IDX_TL_CTRL  = 4'h4;
  localparam logic [3:0] IDX_MARGIN   = 4'h5;
  localparam logic [3:0] IDX_DEV_CAP  = 4'h6;
  localparam logic [3:0] IDX_LINK_CAP = 4'h7;
  localparam logic [3:0] IDX_DEV_CAP2 = 4'h8;

  // destination bit positions
  localparam int POS_MPS      = 0;
  localparam int POS_ASPM     = 10;
  localparam int POS_RBER     = 15;
  localparam int POS_MSI_DIS  = 14;
  localparam int POS_CPAR_DIS = 15;
  localparam int POS_PM_DIS   = 13;
  localparam int POS_ORDER5   = 5;
  localparam int POS_LBN      = 21;
  localparam int POS_FREEZE   = 6;
  localparam int POS_SOF_LAT  = 0;
  localparam int POS_SURPRISE = 19;
  localparam int POS_PM_DSEL  = 1;
  localparam int POS_LTR      = 12;
  localparam int POS_4KB      = 3;
  localparam int POS_MARGIN   = 0;
  localparam int POS_OBFF     = 18;
  localparam int POS_NOMDRV   = 16;
  localparam int POS_GEN2     = 31;
  localparam int POS_DEEMPH   = 16;
  localparam int POS_INTA     = 8;

  // source bit positions inside a preload word
  localparam int SRC_MPS      = 0;
  localparam int SRC_ASPM     = 2;
  localparam int SRC_RBER     = 4;
  localparam int SRC_MSI_DIS  = 5;
  localparam int SRC_CPAR_DIS = 6;
  localparam int SRC_PM_DIS   = 7;
  localparam int SRC_ORDER5   = 8;
  localparam int SRC_LBN      = 9;
  localparam int SRC_FREEZE   = 10;
  localparam int SRC_SOF_LAT  = 11;
  localparam int SRC_SURPRISE = 12;
  localparam int SRC_PM_DSEL  = 13;
  localparam int SRC_LTR      = 14;
  localparam int SRC_TOP      = 15;
  localparam int SRC_FIELD3   = 0;

  // ports that receive the upper-port-only fields
  localparam logic [NUM_PORTS-1:0] HI_PORTS = 3'h6;

  // control and status registers of the loader
  localparam logic [AV_ADDR_W-1:0] CTRL_ADDR = 10'h300;
  localparam logic [AV_ADDR_W-1:0] STAT_ADDR = 10'h304;
  localparam int CTRL_RELOAD_BIT  = 0;
  localparam int STAT_DONE_BIT    = 0;
  localparam int STAT_LOADING_BIT = 1;
  localparam int STAT_COUNT_POS   = 8;

  // reset values
  localparam logic [WORD_W-1:0] RST_IMAGE = 32'h0;
  localparam logic [7:0]        RST_COUNT = 8'h0;

  typedef logic [WORD_W-1:0] reg_word_t;
  typedef logic [NUM_REGS-1:0][WORD_W-1:0] reg_set_t;
  typedef logic [NUM_PORTS-1:0][NUM_REGS-1:0][WORD_W-1:0] image_t;
  typedef enum logic {LOADING, READY} fsm_t;

  // offset to {valid, index}
  function automatic logic [4:0] ofs_to_idx(input logic [7:0] ofs);
    unique case (ofs)
      OFS_INT_PIN:  ofs_to_idx = {1'b1, IDX_INT_PIN};
      OFS_CAP_DIS:  ofs_to_idx = {1'b1, IDX_CAP_DIS};
      OFS_PHY0:     ofs_to_idx = {1'b1, IDX_PHY0};
      OFS_PHY1:     ofs_to_idx = {1'b1, IDX_PHY1};
      OFS_TL_CTRL:  ofs_to_idx = {1'b1, IDX_TL_CTRL};
      OFS_MARGIN:   ofs_to_idx = {1'b1, IDX_MARGIN};
      OFS_DEV_CAP:  ofs_to_idx = {1'b1, IDX_DEV_CAP};
      OFS_LINK_CAP: ofs_to_idx = {1'b1, IDX_LINK_CAP};
      OFS_DEV_CAP2: ofs_to_idx = {1'b1, IDX_DEV_CAP2};
      default:      ofs_to_idx = 5'h00;
    endcase
  endfunction : ofs_to_idx

endpackage : cfg_loader_pkg
`default_nettype wire

/* File: verilog/cfg_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
  import cfg_loader_pkg::*;
  // address decode group
  logic [AV_ADDR_W-1:0] bus_addr;
  logic [1:0]           dec_port;
  logic [3:0]           dec_idx;
  logic                 dec_img;
  logic                 dec_ctrl;
  logic                 dec_stat;
  // preload word unpack group
  logic [7:0]           ee_addr;
  logic [EE_W-1:0]      ee_data;
  logic                 upd_hit;
  reg_set_t             upd_mask_all;
  reg_set_t             upd_mask_hi;
  reg_set_t             upd_value;

  modport core (output bus_addr, ee_addr, ee_data,
                input dec_port, dec_idx, dec_img, dec_ctrl, dec_stat,
                input upd_hit, upd_mask_all, upd_mask_hi, upd_value);
  modport decode (input bus_addr,
                  output dec_port, dec_idx, dec_img, dec_ctrl, dec_stat);
  modport unpack (input ee_addr, ee_data,
                  output upd_hit, upd_mask_all, upd_mask_hi, upd_value);
endinterface : cfg_link_if
`default_nettype wire

/* File: verilog/cfg_addr_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module cfg_addr_decode (
  cfg_link_if.decode lnk
);
  import cfg_loader_pkg::*;

  logic [4:0] hit;

  // split the byte address into port and register
  assign hit          = ofs_to_idx(lnk.bus_addr[7:0]);
  assign lnk.dec_port = lnk.bus_addr[9:8];
  assign lnk.dec_idx  = hit[3:0];
  assign lnk.dec_img  = hit[4] && (32'(lnk.bus_addr[9:8]) < NUM_PORTS);
  assign lnk.dec_ctrl = (lnk.bus_addr == CTRL_ADDR);
  assign lnk.dec_stat = (lnk.bus_addr == STAT_ADDR);
endmodule : cfg_addr_decode
`default_nettype wire

/* File: verilog/cfg_word_unpack.sv */
`timescale 1ns/1ps
`default_nettype none
module cfg_word_unpack (
  cfg_link_if.unpack lnk
);
  import cfg_loader_pkg::*;

  // place each preload field at its register position
  always_comb begin
    lnk.upd_hit      = 1'b1;
    lnk.upd_mask_all = '0;
    lnk.upd_mask_hi  = '0;
    lnk.upd_value    = '0;
    unique case (lnk.ee_addr)
      EE_WORD_ATTR: begin
        lnk.upd_mask_all[IDX_DEV_CAP][POS_MPS +: 2] = 2'h3;
        lnk.upd_value[IDX_DEV_CAP][POS_MPS +: 2] =
          lnk.ee_data[SRC_MPS +: 2];
        lnk.upd_mask_all[IDX_LINK_CAP][POS_ASPM +: 2] = 2'h3;
        lnk.upd_value[IDX_LINK_CAP][POS_ASPM +: 2] =
          lnk.ee_data[SRC_ASPM +: 2];
        lnk.upd_mask_all[IDX_DEV_CAP][POS_RBER] = 1'b1;
        lnk.upd_value[IDX_DEV_CAP][POS_RBER] = lnk.ee_data[SRC_RBER];
        lnk.upd_mask_all[IDX_CAP_DIS][POS_MSI_DIS] = 1'b1;
        lnk.upd_value[IDX_CAP_DIS][POS_MSI_DIS] = lnk.ee_data[SRC_MSI_DIS];
        lnk.upd_mask_all[IDX_PHY0][POS_CPAR_DIS] = 1'b1;
        lnk.upd_value[IDX_PHY0][POS_CPAR_DIS] = lnk.ee_data[SRC_CPAR_DIS];
        lnk.upd_mask_all[IDX_CAP_DIS][POS_PM_DIS] = 1'b1;
        lnk.upd_value[IDX_CAP_DIS][POS_PM_DIS] = lnk.ee_data[SRC_PM_DIS];
        lnk.upd_mask_all[IDX_TL_CTRL][POS_ORDER5] = 1'b1;
        lnk.upd_value[IDX_TL_CTRL][POS_ORDER5] = lnk.ee_data[SRC_ORDER5];
        lnk.upd_mask_hi[IDX_LINK_CAP][POS_LBN] = 1'b1;
        lnk.upd_value[IDX_LINK_CAP][POS_LBN] = lnk.ee_data[SRC_LBN];
        lnk.upd_mask_all[IDX_TL_CTRL][POS_FREEZE] = 1'b1;
        lnk.upd_value[IDX_TL_CTRL][POS_FREEZE] = lnk.ee_data[SRC_FREEZE];
        lnk.upd_mask_all[IDX_TL_CTRL][POS_SOF_LAT] = 1'b1;
        lnk.upd_value[IDX_TL_CTRL][POS_SOF_LAT] = lnk.ee_data[SRC_SOF_LAT];
        lnk.upd_mask_all[IDX_LINK_CAP][POS_SURPRISE] = 1'b1;
        lnk.upd_value[IDX_LINK_CAP][POS_SURPRISE] =
          lnk.ee_data[SRC_SURPRISE];
        lnk.upd_mask_all[IDX_TL_CTRL][POS_PM_DSEL] = 1'b1;
        lnk.upd_value[IDX_TL_CTRL][POS_PM_DSEL] = lnk.ee_data[SRC_PM_DSEL];
        lnk.upd_mask_all[IDX_DEV_CAP2][POS_LTR] = 1'b1;
        lnk.upd_value[IDX_DEV_CAP2][POS_LTR] = lnk.ee_data[SRC_LTR];
        lnk.upd_mask_all[IDX_TL_CTRL][POS_4KB] = 1'b1;
        lnk.upd_value[IDX_TL_CTRL][POS_4KB] = lnk.ee_data[SRC_TOP];
      end
      EE_WORD_MARGIN: begin
        lnk.upd_mask_all[IDX_MARGIN][POS_MARGIN +: FIELD3_W] = '1;
        lnk.upd_value[IDX_MARGIN][POS_MARGIN +: FIELD3_W] =
          lnk.ee_data[SRC_FIELD3 +: FIELD3_W];
        lnk.upd_mask_all[IDX_DEV_CAP2][POS_OBFF] = 1'b1;
        lnk.upd_value[IDX_DEV_CAP2][POS_OBFF] = lnk.ee_data[SRC_TOP];
      end
      EE_WORD_NOMDRV: begin
        lnk.upd_mask_all[IDX_PHY0][POS_NOMDRV +: FIELD3_W] = '1;
        lnk.upd_value[IDX_PHY0][POS_NOMDRV +: FIELD3_W] =
          lnk.ee_data[SRC_FIELD3 +: FIELD3_W];
        lnk.upd_mask_all[IDX_TL_CTRL][POS_GEN2] = 1'b1;
        lnk.upd_value[IDX_TL_CTRL][POS_GEN2] = lnk.ee_data[SRC_TOP];
      end
      EE_WORD_DEEMPH: begin
        lnk.upd_mask_all[IDX_PHY1][POS_DEEMPH +: FIELD3_W] = '1;
        lnk.upd_value[IDX_PHY1][POS_DEEMPH +: FIELD3_W] =
          lnk.ee_data[SRC_FIELD3 +: FIELD3_W];
        lnk.upd_mask_hi[IDX_INT_PIN][POS_INTA] = 1'b1;
        lnk.upd_value[IDX_INT_PIN][POS_INTA] = lnk.ee_data[SRC_TOP];
      end
      default: lnk.upd_hit = 1'b0;
    endcase
  end
endmodule : cfg_word_unpack
`default_nettype wire

/* File: dv/ee_word_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ee_word_model (
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_arst_n,
  // stream control from the bench
  input  wire logic             i_start,
  input  wire logic             i_slow,
  input  wire logic [3:0][15:0] i_words,
  // preload stream towards the loader
  output logic                  o_ee_valid,
  output logic [7:0]            o_ee_addr,
  output logic [15:0]           o_ee_data,
  output logic                  o_ee_last,
  output logic                  o_busy
);
  logic [2:0] idx;
  logic       gap;

  // sends words 0c..12 in order, then the end pulse; slow adds idle gaps
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {o_ee_valid, o_ee_last, o_busy, gap} <= 4'h0;
      o_ee_addr <= 8'hff;
      o_ee_data <= 16'hffff;
      idx <= 3'h0;
    end else begin
      o_ee_valid <= 1'b0;
      o_ee_last <= 1'b0;
      // released lines do not keep the last value
      if (o_ee_valid) begin
        o_ee_addr <= ~o_ee_addr;
        o_ee_data <= ~o_ee_data;
      end
      if (i_start && !o_busy) begin
        o_busy <= 1'b1;
        idx <= 3'h0;
        gap <= 1'b0;
      end else if (o_busy) begin
        if (gap) begin
          gap <= 1'b0;
        end else if (idx == 3'h4) begin
          o_ee_last <= 1'b1;
          o_busy <= 1'b0;
        end else begin
          o_ee_valid <= 1'b1;
          o_ee_addr <= 8'h0c + {4'h0, idx, 1'b0};
          o_ee_data <= i_words[idx[1:0]];
          idx <= idx + 3'h1;
          gap <= i_slow;
        end
      end
    end
  end
endmodule : ee_word_model
`default_nettype wire

/* File: dv/ee_loader_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ee_loader_chk
  import cfg_loader_pkg::*;
(
  // clock and reset
  input wire logic                              i_ref_clk,
  input wire logic                              i_arst_n,
  // watched inputs
  input wire logic                              i_ce,
  input wire logic                              i_ee_valid,
  input wire logic [7:0]                        i_ee_addr,
  input wire logic [cfg_loader_pkg::EE_W-1:0]   i_ee_data,
  input wire logic                              i_ee_last,
  input wire logic                              i_avs_read,
  input wire logic                              i_avs_write,
  // watched outputs
  input wire logic                              o_avs_waitrequest,
  input wire logic                              o_load_done,
  input wire cfg_loader_pkg::image_t            o_cfg_image,
  input wire logic [cfg_loader_pkg::NUM_PORTS-1:0] o_gen2_mode,
  input wire logic [cfg_loader_pkg::NUM_PORTS-1:0] o_msi_disable,
  input wire logic [cfg_loader_pkg::NUM_PORTS-1:0] o_pm_disable,
  input wire logic [cfg_loader_pkg::NUM_PORTS-1:0] o_short_sof_latency,
  input wire logic [cfg_loader_pkg::NUM_PORTS-1:0] o_inta_request
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // a preload word the loader must take at this edge
  logic ld;
  assign ld = i_ce && i_ee_valid && !o_load_done;

  wait_loading_a: assert property (!o_load_done |-> o_avs_waitrequest)
    else $error("bus answered while loading");
  ack_single_a: assert property (
    i_ce && !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("bus answer longer than one cycle");
  ack_prompt_a: assert property (
    i_ce && o_load_done && (i_avs_read || i_avs_write)
    && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer late");
  done_after_last_a: assert property (
    i_ce && i_ee_last |=> o_load_done)
    else $error("done not set after end of preload");
  attr_load_a: assert property (
    ld && i_ee_addr == EE_WORD_ATTR |=>
    o_cfg_image[0][IDX_DEV_CAP][1:0] == $past(i_ee_data[1:0])
    && o_cfg_image[2][IDX_LINK_CAP][11:10] == $past(i_ee_data[3:2])
    && o_cfg_image[1][IDX_LINK_CAP][21] == $past(i_ee_data[9]))
    else $error("attribute word not unpacked");
  port0_keep_a: assert property (
    ld && i_ee_addr == EE_WORD_ATTR |=>
    $stable(o_cfg_image[0][IDX_LINK_CAP][21]))
    else $error("port 0 got an upper-port field");
  margin_load_a: assert property (
    ld && i_ee_addr == EE_WORD_MARGIN |=>
    o_cfg_image[1][IDX_MARGIN][14:0] == $past(i_ee_data[14:0])
    && o_cfg_image[2][IDX_DEV_CAP2][18] == $past(i_ee_data[15]))
    else $error("margin word not unpacked");
  nomdrv_load_a: assert property (
    ld && i_ee_addr == EE_WORD_NOMDRV |=>
    o_cfg_image[2][IDX_PHY0][30:16] == $past(i_ee_data[14:0])
    && o_gen2_mode == {3{$past(i_ee_data[15])}})
    else $error("drive level word not unpacked");
  deemph_load_a: assert property (
    ld && i_ee_addr == EE_WORD_DEEMPH |=>
    o_cfg_image[0][IDX_PHY1][30:16] == $past(i_ee_data[14:0])
    && o_inta_request[2:1] == {2{$past(i_ee_data[15])}}
    && $stable(o_cfg_image[0][IDX_INT_PIN][8]))
    else $error("de-emphasis word not unpacked");
  sof_inverse_a: assert property (o_short_sof_latency == ~{
    o_cfg_image[2][IDX_TL_CTRL][0], o_cfg_image[1][IDX_TL_CTRL][0],
    o_cfg_image[0][IDX_TL_CTRL][0]})
    else $error("short latency level wrong");
  cap_mirror_a: assert property (
    o_msi_disable[1] == o_cfg_image[1][IDX_CAP_DIS][14]
    && o_pm_disable[2] == o_cfg_image[2][IDX_CAP_DIS][13])
    else $error("capability disable level wrong");

  // main scenarios
  load_done_c: cover property ($rose(o_load_done));
  read_ack_c: cover property (i_avs_read && !o_avs_waitrequest);
  write_ack_c: cover property (i_avs_write && !o_avs_waitrequest);
endmodule : ee_loader_chk
bind eeprom_config_word_loader ee_loader_chk i_chk (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
  .i_ee_valid(i_ee_valid), .i_ee_addr(i_ee_addr), .i_ee_data(i_ee_data),
  .i_ee_last(i_ee_last), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .o_load_done(o_load_done),
  .o_cfg_image(o_cfg_image), .o_gen2_mode(o_gen2_mode),
  .o_msi_disable(o_msi_disable), .o_pm_disable(o_pm_disable),
  .o_short_sof_latency(o_short_sof_latency),
  .o_inta_request(o_inta_request));
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cfg_loader_pkg::*;
  logic clk, rst_n, ce, start, slow, rd, wr, wreq, done;
  logic ee_valid, ee_last, ee_busy;
  logic [7:0] ee_addr;
  logic [15:0] ee_data;
  logic [3:0][15:0] words;
  logic [AV_ADDR_W-1:0] adr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] be;
  image_t img;
  logic [2:0] gen2, msi, pm, sof, inta;
  int failures, checks_done;
  logic [7:0] offs [9] = '{OFS_INT_PIN, OFS_CAP_DIS, OFS_PHY0, OFS_PHY1,
    OFS_TL_CTRL, OFS_MARGIN, OFS_DEV_CAP, OFS_LINK_CAP, OFS_DEV_CAP2};
  localparam logic [3:0][15:0] PAT_A = 64'h3c5a_c3a5_5a3c_a5c3;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  eeprom_config_word_loader i_dut (.i_ref_clk(clk), .i_arst_n(rst_n),
    .i_ce(ce), .i_ee_valid(ee_valid), .i_ee_addr(ee_addr),
    .i_ee_data(ee_data), .i_ee_last(ee_last), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_load_done(done), .o_cfg_image(img),
    .o_gen2_mode(gen2), .o_msi_disable(msi), .o_pm_disable(pm),
    .o_short_sof_latency(sof), .o_inta_request(inta));
  ee_word_model i_ee (.i_ref_clk(clk), .i_arst_n(rst_n), .i_start(start),
    .i_slow(slow), .i_words(words), .o_ee_valid(ee_valid),
    .o_ee_addr(ee_addr), .o_ee_data(ee_data), .o_ee_last(ee_last),
    .o_busy(ee_busy));

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string s);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, s, seen, exp);
    end
  endtask : chk

  task hang(input string s);
    failures++;
    $display("MISMATCH at %0t: %s timed out", $time, s);
    report_and_stop();
  endtask : hang

  // one avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [9:0] a, input logic [31:0] v,
           input logic [3:0] b);
    int n;
    @(posedge clk);
    adr <= a; wdata <= v; be <= b; rd <= !w; wr <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 200);
    if (wreq !== 1'b0) hang("bus");
    d = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  function automatic logic [31:0] exp_reg(input int p, input logic [7:0] o,
                                          input logic [3:0][15:0] w);
    logic [31:0] r;
    r = '0;
    case (o)
      OFS_INT_PIN: r[8] = (p > 0) && w[3][15];
      OFS_CAP_DIS: r[14:13] = {w[0][5], w[0][7]};
      OFS_PHY0: r = {1'b0, w[2][14:0], w[0][6], 15'h0};
      OFS_PHY1: r[30:16] = w[3][14:0];
      OFS_TL_CTRL: r = {w[2][15], 24'h0, w[0][10], w[0][8],
        1'b0, w[0][15], 1'b0, w[0][13], w[0][11]};
      OFS_MARGIN: r[14:0] = w[1][14:0];
      OFS_DEV_CAP: r = {16'h0, w[0][4], 13'h0, w[0][1:0]};
      OFS_LINK_CAP: r = {10'h0, (p > 0) && w[0][9], 1'b0,
        w[0][12], 7'h0, w[0][3:2], 10'h0};
      OFS_DEV_CAP2: r = {13'h0, w[1][15], 5'h0, w[0][14], 12'h0};
      default: r = '0;
    endcase
    return r;
  endfunction : exp_reg

  // streams four words from the model and waits for the end of preload
  task load(input logic [3:0][15:0] w, input logic s);
    int n;
    @(posedge clk);
    words <= w; slow <= s; start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((ee_busy !== 1'b0 || done !== 1'b1) && n < 100);
    if (n >= 100) hang("preload");
  endtask : load

  // reads every image register of every port and the control levels
  task verify(input logic [3:0][15:0] w, input string s);
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        bus(1'b0, AV_ADDR_W'(p * 256 + offs[i]), 32'h0, 4'hf);
        chk(d, exp_reg(p, offs[i], w), s);
      end
    end
    chk({17'h0, gen2, msi, pm, sof, inta},
      {17'h0, {3{w[2][15]}}, {3{w[0][5]}}, {3{w[0][7]}},
      {3{~w[0][11]}}, {2{w[3][15]}}, 1'b0}, s);
    $display("test %s done", s);
  endtask : verify

  // reset, two loads, refusal in ready, byte lanes, unmapped space
  initial begin
    {rst_n, start, slow, rd, wr} = 5'h0;
    ce = 1'b1;
    adr = '0;
    wdata = '0;
    be = 4'hf;
    words = '0;
    repeat (16) @(posedge clk);
    chk({30'h0, wreq, done}, 32'h2, "reset bus");
    chk({29'h0, sof}, 32'h7, "reset sof");
    chk({31'h0, |img}, 32'h0, "reset image");
    rst_n <= 1'b1;
    load(PAT_A, 1'b0);
    verify(PAT_A, "load a");
    bus(1'b1, CTRL_ADDR, 32'h1, 4'hf);
    @(posedge clk);
    chk({31'h0, done}, 32'h0, "reload");
    load(~PAT_A, 1'b1);
    verify(~PAT_A, "load b");
    bus(1'b0, STAT_ADDR, 32'h0, 4'hf);
    chk(d, 32'h0000_0401, "status");
    load(64'hffff_ffff_ffff_ffff, 1'b0);
    verify(~PAT_A, "ready ignores words");
    bus(1'b1, 10'h18c, 32'hffff_ffff, 4'h3);
    bus(1'b0, 10'h18c, 32'h0, 4'hf);
    chk(d, exp_reg(1, OFS_TL_CTRL, ~PAT_A) | 32'h0000_ffff, "lanes");
    bus(1'b1, 10'h0a0, 32'hffff_ffff, 4'hf);
    bus(1'b0, 10'h0a0, 32'h0, 4'hf);
    chk(d, 32'h0, "unmapped");
    $display("test bus access done");
    // a low clock enable drops the whole preload stream
    bus(1'b1, CTRL_ADDR, 32'h1, 4'hf);
    ce <= 1'b0;
    @(posedge clk);
    words <= PAT_A;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (12) @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    chk({31'h0, done}, 32'h0, "frozen done");
    chk(img[2][IDX_PHY1], exp_reg(2, OFS_PHY1, ~PAT_A), "frozen");
    $display("test clock enable done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
